// >>> include/accel_mode_regs.svh
`ifndef ACCEL_MODE_REGS_SVH
`define ACCEL_MODE_REGS_SVH

// Register offsets.
`define REG_RATE_AND_POWER_CONTROL 8'h20
`define REG_RESOLUTION_CONTROL_ALT 8'h22
`define REG_RESOLUTION_CONTROL 8'h23
`define REG_ORIENTATION_CONFIG 8'h30
`define REG_STATUS 8'h31
`define REG_ACTIVITY_THRESHOLD 8'h3e
`define REG_ACTIVITY_DURATION 8'h3f

// Reset values.
`define RST_CONTROL 8'h00
`define RST_ACTIVITY 8'h00

// Field positions.
`define RATE_SELECT_HI 7
`define RATE_SELECT_LO 4
`define LOW_POWER_ENABLE_BIT 3
`define HIGH_RESOLUTION_SELECT_BIT 3
`define ORIENT_ENABLE_BIT 0
`define ORIENT_FOUR_DIRECTION_BIT 1

// Data rate codes and their rates in Hz.
`define RATE_POWER_DOWN 4'h0
`define RATE_CODE_10HZ 4'h2
`define SLEEP_RATE_HZ 10

// Sample truncation masks on the 12-bit converter word.
`define MASK_8BIT 12'hff0
`define MASK_10BIT 12'hffc
`define MASK_12BIT 12'hfff

// Settling in sample periods.
`define SETTLE_SHORT 3'h1
`define SETTLE_LONG 3'h7

// Timing.
`define CLK_MHZ 50
`define TURN_ON_LOW_POWER_US 1000
`define TURN_ON_NORMAL_US 1600
`define SECOND_CYCLES 50000000

// Orientation level on the upper eight magnitude bits.
`define ORIENT_LEVEL 8'h30

`endif

// >>> include/accel_mode_pkg.sv
package accel_mode_pkg;

    typedef enum logic [1:0] {
        MODE_LOW_POWER,
        MODE_NORMAL,
        MODE_HIGH_RES
    } mode_t;

    typedef struct packed {
        logic [11:0] x;
        logic [11:0] y;
        logic [11:0] z;
    } axes_t;

endpackage

// >>> hw/accel_mode_ctrl.sv
`timescale 1ns/1ps
`include "accel_mode_regs.svh"

module accel_mode_ctrl #(
    parameter int SECOND_CYCLES = `SECOND_CYCLES,
    parameter int TURN_ON_LP_CYCLES = `TURN_ON_LOW_POWER_US * `CLK_MHZ,
    parameter int TURN_ON_NORMAL_CYCLES = `TURN_ON_NORMAL_US * `CLK_MHZ
) (
    // Clock and reset.
    input wire logic CLK_I,
    input wire logic SRST_I,
    // Register access.
    input wire logic [7:0] REG_ADDR_I,
    input wire logic REG_WE_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic REG_RE_I,
    output logic [7:0] REG_RDATA_O,
    // Converter samples.
    input wire accel_mode_pkg::axes_t SAMPLE_I,
    // Output samples.
    output accel_mode_pkg::axes_t AXES_O,
    output logic DATA_VALID_O,
    output logic SAMPLE_TICK_O,
    // Mode and state.
    output accel_mode_pkg::mode_t MODE_O,
    output logic SLEEPING_O,
    // Orientation.
    output logic [2:0] ORIENT_DIR_O,
    output logic ORIENT_INT_O
);

    // ==========================================================
    // Registers
    // ==========================================================
    logic [7:0] rate_and_power_control;
    logic [7:0] resolution_control_alt;
    logic [7:0] resolution_control;
    logic [7:0] orientation_config;
    logic [7:0] activity_threshold;
    logic [7:0] activity_duration;
    logic sleeping;
    logic [2:0] orient_reported;

    // Host writes only; sleep never modifies these.
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            rate_and_power_control <= `RST_CONTROL;
            resolution_control_alt <= `RST_CONTROL;
            resolution_control <= `RST_CONTROL;
            orientation_config <= `RST_CONTROL;
            activity_threshold <= `RST_ACTIVITY;
            activity_duration <= `RST_ACTIVITY;
        end
        else if (REG_WE_I)
        begin
            unique case (REG_ADDR_I)
                `REG_RATE_AND_POWER_CONTROL: rate_and_power_control <= REG_WDATA_I;
                `REG_RESOLUTION_CONTROL_ALT: resolution_control_alt <= REG_WDATA_I;
                `REG_RESOLUTION_CONTROL: resolution_control <= REG_WDATA_I;
                `REG_ORIENTATION_CONFIG: orientation_config <= REG_WDATA_I;
                `REG_ACTIVITY_THRESHOLD: activity_threshold <= REG_WDATA_I;
                `REG_ACTIVITY_DURATION: activity_duration <= REG_WDATA_I;
                default: ;
            endcase
        end
    end

    wire logic [7:0] status_word = {3'h0, orient_reported, MODE_O == accel_mode_pkg::MODE_HIGH_RES, sleeping};
    wire logic [7:0] next_rdata =
        (REG_ADDR_I == `REG_RATE_AND_POWER_CONTROL) ? rate_and_power_control :
        (REG_ADDR_I == `REG_RESOLUTION_CONTROL_ALT) ? resolution_control_alt :
        (REG_ADDR_I == `REG_RESOLUTION_CONTROL) ? resolution_control :
        (REG_ADDR_I == `REG_ORIENTATION_CONFIG) ? orientation_config :
        (REG_ADDR_I == `REG_STATUS) ? status_word :
        (REG_ADDR_I == `REG_ACTIVITY_THRESHOLD) ? activity_threshold :
        (REG_ADDR_I == `REG_ACTIVITY_DURATION) ? activity_duration : 8'h00;

    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
            REG_RDATA_O <= 8'h00;
        else if (REG_RE_I)
            REG_RDATA_O <= next_rdata;
    end

    // ==========================================================
    // Effective mode and rate
    // ==========================================================
    wire logic host_low_power = rate_and_power_control[`LOW_POWER_ENABLE_BIT];
    wire logic host_high_res = resolution_control[`HIGH_RESOLUTION_SELECT_BIT];
    wire logic [3:0] host_rate = rate_and_power_control[`RATE_SELECT_HI:`RATE_SELECT_LO];

    // While asleep the host bits are not considered.
    wire logic [3:0] eff_rate = sleeping ? `RATE_CODE_10HZ : host_rate;
    wire logic eff_low_power = sleeping | host_low_power;
    wire logic eff_high_res = ~sleeping & host_high_res;

    // Both bits set is left to the host to avoid; low power then wins.
    wire accel_mode_pkg::mode_t next_mode = eff_low_power ? accel_mode_pkg::MODE_LOW_POWER :
        eff_high_res ? accel_mode_pkg::MODE_HIGH_RES : accel_mode_pkg::MODE_NORMAL;

    function automatic logic [31:0] rate_period(input logic [3:0] code, input logic lp);
        int hz;
        hz = 0;
        unique case (code)
            4'h1: hz = 1;
            4'h2: hz = `SLEEP_RATE_HZ;
            4'h3: hz = 25;
            4'h4: hz = 50;
            4'h5: hz = 100;
            4'h6: hz = 200;
            4'h7: hz = 400;
            4'h8: hz = 1620;
            4'h9: hz = lp ? 5376 : 1344;
            default: hz = 0;
        endcase
        rate_period = (hz == 0) ? 32'h0 : 32'(SECOND_CYCLES / hz);
    endfunction

    wire logic [31:0] period = rate_period(eff_rate, eff_low_power);

    // ==========================================================
    // Sample timing and settling
    // ==========================================================
    logic [31:0] tick_cnt;
    logic [3:0] prev_rate;
    logic [31:0] turnon_cnt;
    logic [2:0] settle_cnt;

    wire logic powered = eff_rate != `RATE_POWER_DOWN && period != 32'h0;
    wire logic rate_changed = eff_rate != prev_rate;
    wire logic tick = powered && !rate_changed && tick_cnt >= period - 32'h1;
    wire logic mode_changed = next_mode != MODE_O;
    wire logic power_up = prev_rate == `RATE_POWER_DOWN && powered;
    wire logic high_res_next = next_mode == accel_mode_pkg::MODE_HIGH_RES;
    wire logic sample_ok = tick && !mode_changed && turnon_cnt == 32'h0 && settle_cnt == 3'h0;

    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            tick_cnt <= 32'h0;
            prev_rate <= `RATE_POWER_DOWN;
            MODE_O <= accel_mode_pkg::MODE_NORMAL;
            turnon_cnt <= 32'h0;
            settle_cnt <= 3'h0;
        end
        else
        begin
            prev_rate <= eff_rate;
            MODE_O <= next_mode;
            tick_cnt <= (!powered || rate_changed || tick) ? 32'h0 : tick_cnt + 32'h1;
            if (power_up && next_mode == accel_mode_pkg::MODE_LOW_POWER)
            begin
                turnon_cnt <= 32'(TURN_ON_LP_CYCLES);
                settle_cnt <= 3'h0;
            end
            else if (power_up && next_mode == accel_mode_pkg::MODE_NORMAL)
            begin
                turnon_cnt <= 32'(TURN_ON_NORMAL_CYCLES);
                settle_cnt <= 3'h0;
            end
            else if (power_up || mode_changed)
            begin
                turnon_cnt <= 32'h0;
                settle_cnt <= high_res_next ? `SETTLE_LONG : `SETTLE_SHORT;
            end
            else
            begin
                if (turnon_cnt != 32'h0)
                    turnon_cnt <= turnon_cnt - 32'h1;
                if (tick && turnon_cnt == 32'h0 && settle_cnt != 3'h0)
                    settle_cnt <= settle_cnt - 3'h1;
            end
        end
    end

    // ==========================================================
    // Output words
    // ==========================================================
    wire logic [11:0] mask = (MODE_O == accel_mode_pkg::MODE_LOW_POWER) ? `MASK_8BIT :
        (MODE_O == accel_mode_pkg::MODE_NORMAL) ? `MASK_10BIT : `MASK_12BIT;

    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            AXES_O <= '0;
            DATA_VALID_O <= 1'b0;
            SAMPLE_TICK_O <= 1'b0;
        end
        else
        begin
            SAMPLE_TICK_O <= tick;
            DATA_VALID_O <= sample_ok;
            if (sample_ok)
            begin
                // Truncation keeps the sign bit, so zero reads as 00h.
                AXES_O.x <= SAMPLE_I.x & mask;
                AXES_O.y <= SAMPLE_I.y & mask;
                AXES_O.z <= SAMPLE_I.z & mask;
            end
        end
    end

    // ==========================================================
    // Sleep to wake
    // ==========================================================
    function automatic logic [7:0] mag_hi(input logic [11:0] v);
        logic [11:0] a;
        a = v[11] ? 12'(~v + 12'h1) : v;
        mag_hi = a[11:4];
    endfunction

    wire logic [7:0] mag_x = mag_hi(SAMPLE_I.x);
    wire logic [7:0] mag_y = mag_hi(SAMPLE_I.y);
    wire logic [7:0] mag_z = mag_hi(SAMPLE_I.z);
    wire logic above = mag_x > activity_threshold || mag_y > activity_threshold || mag_z > activity_threshold;
    wire logic sleep_armed = activity_threshold != 8'h00 && host_rate != `RATE_POWER_DOWN;
    logic [7:0] below_cnt;

    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            sleeping <= 1'b0;
            below_cnt <= 8'h00;
        end
        else if (!sleep_armed)
        begin
            sleeping <= 1'b0;
            below_cnt <= 8'h00;
        end
        else if (tick)
        begin
            if (above)
            begin
                sleeping <= 1'b0;
                below_cnt <= 8'h00;
            end
            else if (!sleeping && below_cnt >= activity_duration)
                sleeping <= 1'b1;
            else if (!sleeping)
                below_cnt <= below_cnt + 8'h01;
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
            SLEEPING_O <= 1'b0;
        else
            SLEEPING_O <= sleeping;
    end

    // ==========================================================
    // Orientation
    // ==========================================================
    wire logic four_dir = orientation_config[`ORIENT_FOUR_DIRECTION_BIT];
    wire logic [2:0] cand =
        (mag_x > `ORIENT_LEVEL) ? (SAMPLE_I.x[11] ? 3'h2 : 3'h1) :
        (mag_y > `ORIENT_LEVEL) ? (SAMPLE_I.y[11] ? 3'h4 : 3'h3) :
        (!four_dir && mag_z > `ORIENT_LEVEL) ? (SAMPLE_I.z[11] ? 3'h6 : 3'h5) : 3'h0;
    logic [2:0] cand_prev;
    wire logic stable = cand == cand_prev && cand != 3'h0 && cand != orient_reported;
    wire logic [2:0] next_orient = !orientation_config[`ORIENT_ENABLE_BIT] ? 3'h0 :
        (sample_ok && stable) ? cand : orient_reported;

    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            cand_prev <= 3'h0;
            orient_reported <= 3'h0;
            ORIENT_INT_O <= 1'b0;
        end
        else
        begin
            ORIENT_INT_O <= 1'b0;
            if (!orientation_config[`ORIENT_ENABLE_BIT])
            begin
                cand_prev <= 3'h0;
                orient_reported <= 3'h0;
            end
            else if (sample_ok)
            begin
                cand_prev <= cand;
                if (stable)
                begin
                    orient_reported <= cand;
                    ORIENT_INT_O <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
            ORIENT_DIR_O <= 3'h0;
        else
            ORIENT_DIR_O <= next_orient;
    end

endmodule

// >>> testbench/accel_mode_asserts.sv
`timescale 1ns/1ps
// ====
// Checks on mode, sleep and orientation.
module accel_mode_asserts (
    // Clock and reset.
    input wire logic CLK_I,
    input wire logic SRST_I,
    // Register writes.
    input wire logic [7:0] REG_ADDR_I,
    input wire logic REG_WE_I,
    input wire logic [7:0] REG_WDATA_I,
    // Results.
    input wire accel_mode_pkg::axes_t AXES_O,
    input wire logic DATA_VALID_O,
    input wire logic SAMPLE_TICK_O,
    input wire accel_mode_pkg::mode_t MODE_O,
    input wire logic SLEEPING_O,
    input wire logic [2:0] ORIENT_DIR_O,
    input wire logic ORIENT_INT_O
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (SRST_I);
    logic lp, hr, four;
    int ticks;
    accel_mode_pkg::mode_t host_mode;
    assign host_mode = lp ? accel_mode_pkg::MODE_LOW_POWER :
        hr ? accel_mode_pkg::MODE_HIGH_RES : accel_mode_pkg::MODE_NORMAL;
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            {lp, hr, four} <= 3'h0;
            ticks <= 0;
        end
        else
        begin
            if (REG_WE_I && REG_ADDR_I == 8'h20)
                lp <= REG_WDATA_I[3];
            if (REG_WE_I && REG_ADDR_I == 8'h23)
                hr <= REG_WDATA_I[3];
            if (REG_WE_I && REG_ADDR_I == 8'h30)
                four <= REG_WDATA_I[1];
            ticks <= $changed(MODE_O) ? 0 : ticks + int'(SAMPLE_TICK_O && ticks < 8);
        end
    end
    sequence quiet_s;
        (!SLEEPING_O && !REG_WE_I) [*4];
    endsequence
    lp_mask_a: assert property (DATA_VALID_O && MODE_O == accel_mode_pkg::MODE_LOW_POWER |->
        AXES_O.x[3:0] == 4'h0 && AXES_O.y[3:0] == 4'h0 && AXES_O.z[3:0] == 4'h0) else $error("8-bit mask");
    norm_mask_a: assert property (DATA_VALID_O && MODE_O == accel_mode_pkg::MODE_NORMAL |->
        AXES_O.x[1:0] == 2'h0 && AXES_O.y[1:0] == 2'h0 && AXES_O.z[1:0] == 2'h0) else $error("10-bit mask");
    mode_sel_a: assert property (quiet_s |-> MODE_O == host_mode) else $error("mode select");
    hr_settle_a: assert property (DATA_VALID_O && MODE_O == accel_mode_pkg::MODE_HIGH_RES |->
        ticks >= 6) else $error("12-bit settle");
    valid_tick_a: assert property (DATA_VALID_O |-> SAMPLE_TICK_O) else $error("valid off tick");
    sleep_mode_a: assert property (SLEEPING_O && $past(SLEEPING_O) |->
        MODE_O == accel_mode_pkg::MODE_LOW_POWER) else $error("sleep mode");
    wake_mode_a: assert property ($fell(SLEEPING_O) |-> MODE_O == host_mode) else $error("wake mode");
    orient_pulse_a: assert property (ORIENT_INT_O |-> ORIENT_DIR_O != 3'h0 ##1 !ORIENT_INT_O)
        else $error("orientation pulse");
    four_dir_a: assert property (ORIENT_INT_O && four |-> ORIENT_DIR_O <= 3'h4) else $error("4D uses Z");
endmodule
bind accel_mode_ctrl accel_mode_asserts accel_mode_asserts_inst (.CLK_I, .SRST_I, .REG_ADDR_I, .REG_WE_I,
    .REG_WDATA_I, .AXES_O, .DATA_VALID_O, .SAMPLE_TICK_O, .MODE_O, .SLEEPING_O, .ORIENT_DIR_O, .ORIENT_INT_O);

// >>> testbench/accel_host.sv
`timescale 1ns/1ps
// ====
// Host on the register port.
module accel_host (
    // Clock.
    input wire logic clk_i,
    // Register port.
    output logic [7:0] addr_o,
    output logic we_o,
    output logic [7:0] wdata_o,
    output logic re_o,
    input wire logic [7:0] rdata_i
);
    initial
    begin
        {addr_o, we_o, wdata_o, re_o} = 18'h0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        {addr_o, wdata_o, we_o} <= {a, d, 1'b1};
        @(posedge clk_i);
        {addr_o, wdata_o, we_o} <= {~a, ~d, 1'b0};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        {addr_o, re_o} <= {a, 1'b1};
        @(posedge clk_i);
        {addr_o, re_o} <= {~a, 1'b0};
        @(posedge clk_i);
        d = rdata_i;
    endtask
endmodule

// >>> testbench/accel_mode_and_sleep_wake_ctrl_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
    $display("CHECK FAILED at %0t: got %h, expected %h", $time, g, e); end end
// ====
// Bench with a sample model.
module accel_mode_and_sleep_wake_ctrl_bench;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic we, re, dv, tick, sleeping, oint;
    logic [7:0] addr, wdata, rdata, r;
    logic [2:0] odir;
    accel_mode_pkg::axes_t smp = '0;
    accel_mode_pkg::axes_t axes;
    accel_mode_pkg::mode_t mode;
    accel_mode_pkg::mode_t exp_mode = accel_mode_pkg::MODE_NORMAL;
    int err_total = 0;
    int samples_checked = 0;
    int valids = 0;
    int pulses = 0;
    int big = 0;
    int k;
    int ord[4] = '{0, 1, 2, 0};
    assign k = sleeping ? 8 : 8 + 2 * int'(exp_mode);
    accel_mode_ctrl #(.SECOND_CYCLES(10000), .TURN_ON_LP_CYCLES(20), .TURN_ON_NORMAL_CYCLES(32))
        accel_mode_ctrl_inst (.CLK_I(clk), .SRST_I(srst), .REG_ADDR_I(addr), .REG_WE_I(we), .REG_WDATA_I(wdata),
        .REG_RE_I(re), .REG_RDATA_O(rdata), .SAMPLE_I(smp), .AXES_O(axes), .DATA_VALID_O(dv), .SAMPLE_TICK_O(tick),
        .MODE_O(mode), .SLEEPING_O(sleeping), .ORIENT_DIR_O(odir), .ORIENT_INT_O(oint));
    accel_host accel_host_inst (.clk_i(clk), .addr_o(addr), .we_o(we), .wdata_o(wdata), .re_o(re), .rdata_i(rdata));
    function automatic logic [11:0] cut(input logic [11:0] v, input int keep);
        return v & ~((12'h1 << (12 - keep)) - 12'h1);
    endfunction
    function automatic logic [11:0] axis(input bit hi);
        return hi ? 12'h400 | 12'($urandom_range(255)) : 12'($urandom_range(255)) - 12'h080;
    endfunction
    always @(posedge clk)
    begin
        if (dv)
        begin
            valids++;
            `CHK(axes, {cut(smp.x, k), cut(smp.y, k), cut(smp.z, k)})
        end
        if (tick)
            smp <= {axis(big == 1), axis(0), axis(big == 2)};
        if (oint)
            pulses++;
    end
    task automatic wait_valid(input int n);
        int t0;
        t0 = valids + n;
        for (int i = 0; i < 3000 && valids < t0; i++)
            @(posedge clk);
        `CHK(valids >= t0, 1'b1)
    endtask
    task automatic wait_sleep(input logic s);
        for (int i = 0; i < 3000 && sleeping !== s; i++)
            @(posedge clk);
        `CHK(sleeping, s)
    endtask
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
        forever #10 clk = ~clk;
    initial
    begin
        #(20 * 40000);
        err_total++;
        give_verdict();
    end
    initial
    begin
        void'($urandom(32'h9fa4));
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        accel_host_inst.rd(8'h20, r);
        `CHK(r, 8'h00)
        accel_host_inst.rd(8'h5a, r);
        `CHK(r, 8'h00)
        $display("Reset test done");
        for (int i = 0; i < 4; i++)
        begin
            accel_host_inst.wr(8'h23, ord[i] == 2 ? 8'h08 : 8'h00);
            accel_host_inst.wr(8'h20, ord[i] == 0 ? 8'h58 : 8'h50);
            exp_mode <= accel_mode_pkg::mode_t'(ord[i]);
            wait_valid(2);
            `CHK(mode, exp_mode)
        end
        $display("Mode test done");
        accel_host_inst.wr(8'h20, 8'h50);
        exp_mode <= accel_mode_pkg::MODE_NORMAL;
        accel_host_inst.wr(8'h3f, 8'h02);
        accel_host_inst.wr(8'h3e, 8'h10);
        wait_sleep(1'b1);
        accel_host_inst.wr(8'h23, 8'h08);
        exp_mode <= accel_mode_pkg::MODE_HIGH_RES;
        wait_valid(1);
        accel_host_inst.rd(8'h20, r);
        `CHK(r, 8'h50)
        accel_host_inst.rd(8'h31, r);
        `CHK(r, 8'h01)
        big <= 1;
        wait_sleep(1'b0);
        wait_valid(1);
        `CHK(mode, accel_mode_pkg::MODE_HIGH_RES)
        $display("Sleep test done");
        pulses = 0;
        accel_host_inst.wr(8'h30, 8'h01);
        wait_valid(3);
        `CHK(odir, 3'h1)
        accel_host_inst.wr(8'h30, 8'h03);
        big <= 2;
        wait_valid(3);
        `CHK(odir, 3'h1)
        accel_host_inst.wr(8'h30, 8'h01);
        wait_valid(3);
        `CHK(odir, 3'h5)
        `CHK(pulses, 2)
        $display("Orientation test done");
        give_verdict();
    end
endmodule
